// ---- verilog/bbw_wrapper.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbw_wrapper #(
  parameter int MASTER_ID_WIDTH = 1,
  parameter bit ENDIAN_SELECT   = 1'b0
) (
  // Clock and reset
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST_B,
  // Upstream port, from the processor
  input  wire logic [31:0]                HADDR_S,
  input  wire logic [1:0]                 HTRANS_S,
  input  wire logic                       HWRITE_S,
  input  wire logic [2:0]                 HSIZE_S,
  input  wire logic [2:0]                 HBURST_S,
  input  wire logic [3:0]                 HPROT_S,
  input  wire logic [MASTER_ID_WIDTH-1:0] HMASTER_S,
  input  wire logic                       HMASTLOCK_S,
  input  wire logic [31:0]                HWDATA_S,
  output logic                            HREADYOUT_S,
  output logic                            HRESP_S,
  output logic [31:0]                     HRDATA_S,
  // Downstream port, to the slaves
  output logic [31:0]                     HADDR_M,
  output logic [1:0]                      HTRANS_M,
  output logic                            HWRITE_M,
  output logic [2:0]                      HSIZE_M,
  output logic [2:0]                      HBURST_M,
  output logic [3:0]                      HPROT_M,
  output logic [MASTER_ID_WIDTH-1:0]      HMASTER_M,
  output logic                            HMASTLOCK_M,
  output logic [31:0]                     HWDATA_M,
  input  wire logic [31:0]                HRDATA_M,
  input  wire logic                       DOWNSTREAM_READY_OUT,
  input  wire logic                       DOWNSTREAM_RESPONSE
);

  bbw_pkg::bbw_state_t          st_r, st_nxt;
  logic                         rd_alias_r, rd_alias_nxt;
  logic [31:0]                  addr_r, addr_nxt;
  logic [2:0]                   size_r, size_nxt;
  logic [2:0]                   bit_r, bit_nxt;
  logic [3:0]                   prot_r, prot_nxt;
  logic [MASTER_ID_WIDTH-1:0]   mst_r, mst_nxt;
  logic [31:0]                  merged_r, merged_nxt;
  logic                         is_alias;
  logic                         take_s;
  logic                         pass_addr;
  logic [31:0]                  remap;

  bbw_lane_if lane_if ();

  bbw_bit_lane #(
    .ENDIAN_SELECT (ENDIAN_SELECT)
  ) u_lane (
    .lp (lane_if.lane)
  );

  assign lane_if.rdata    = HRDATA_M;
  assign lane_if.byte_sel = addr_r[1:0];
  assign lane_if.bit_num  = bit_r;
  assign lane_if.wbit     = HWDATA_S[0];

  // Keeps the remapped address legal for halfword and word transfers
  function automatic logic [31:0] align_addr(input logic [31:0] a, input logic [2:0] sz);
    logic [31:0] r;
    r = a;
    if (sz != bbw_pkg::HSIZE_BYTE) r[0] = 1'b0;
    if (sz[1]) r[1] = 1'b0;
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Alias decode
  // --------------------------------------------------------------------------
  always_comb begin
    // Only data accesses are redirected; fetches go through as they are
    is_alias = HPROT_S[0] && ((HADDR_S[31:25] == bbw_pkg::ALIAS_SRAM_TAG) ||
                              (HADDR_S[31:25] == bbw_pkg::ALIAS_PERI_TAG));
    // Byte offset from bits 24:5, bit number from bits 4:2
    remap    = {HADDR_S[31:28], bbw_pkg::BAND_GAP, HADDR_S[24:5]};
  end

  // --------------------------------------------------------------------------
  // Upstream answer
  // --------------------------------------------------------------------------
  always_comb begin
    case (st_r)
      bbw_pkg::ST_PASS,
      bbw_pkg::ST_WB_DATA: HREADYOUT_S = DOWNSTREAM_READY_OUT;
      // A failed read ends the sequence at once with the error
      bbw_pkg::ST_RMW_RD:  HREADYOUT_S = DOWNSTREAM_READY_OUT && DOWNSTREAM_RESPONSE;
      default:             HREADYOUT_S = 1'b0;
    endcase
    HRESP_S  = (st_r == bbw_pkg::ST_WB_ADDR) ? bbw_pkg::HRESP_OKAY : DOWNSTREAM_RESPONSE;
    HRDATA_S = rd_alias_r ? {31'h0000_0000, lane_if.rbit} : HRDATA_M;
    take_s   = HREADYOUT_S && HTRANS_S[1];
  end

  // --------------------------------------------------------------------------
  // Downstream address and data
  // --------------------------------------------------------------------------
  always_comb begin
    // The master's next address may only be forwarded once its data phase can end
    pass_addr = (st_r == bbw_pkg::ST_PASS) || (st_r == bbw_pkg::ST_WB_DATA) ||
                ((st_r == bbw_pkg::ST_RMW_RD) && DOWNSTREAM_RESPONSE);
    if (pass_addr) begin
      HADDR_M     = is_alias ? align_addr(remap, HSIZE_S) : HADDR_S;
      HTRANS_M    = HTRANS_S;
      HWRITE_M    = HWRITE_S && !is_alias;
      HSIZE_M     = HSIZE_S;
      HBURST_M    = is_alias ? bbw_pkg::HBURST_SINGLE : HBURST_S;
      HPROT_M     = HPROT_S;
      HMASTER_M   = HMASTER_S;
      HMASTLOCK_M = HMASTLOCK_S || (is_alias && HWRITE_S && HTRANS_S[1]);
    end else begin
      HADDR_M     = align_addr(addr_r, size_r);
      HTRANS_M    = (st_r == bbw_pkg::ST_WB_ADDR) ? bbw_pkg::HTRANS_NONSEQ : bbw_pkg::HTRANS_IDLE;
      HWRITE_M    = (st_r == bbw_pkg::ST_WB_ADDR);
      HSIZE_M     = size_r;
      HBURST_M    = bbw_pkg::HBURST_SINGLE;
      HPROT_M     = prot_r;
      HMASTER_M   = mst_r;
      HMASTLOCK_M = 1'b1;
    end
    HWDATA_M = (st_r == bbw_pkg::ST_WB_DATA) ? merged_r : HWDATA_S;
  end

  // --------------------------------------------------------------------------
  // Sequence control
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    rd_alias_nxt = rd_alias_r;
    addr_nxt     = addr_r;
    size_nxt     = size_r;
    bit_nxt      = bit_r;
    prot_nxt     = prot_r;
    mst_nxt      = mst_r;
    merged_nxt   = merged_r;
    if (HREADYOUT_S) begin
      rd_alias_nxt = take_s && is_alias && !HWRITE_S;
      st_nxt = (take_s && is_alias && HWRITE_S) ? bbw_pkg::ST_RMW_RD : bbw_pkg::ST_PASS;
      if (take_s && is_alias) begin
        addr_nxt = remap;
        size_nxt = HSIZE_S;
        bit_nxt  = HADDR_S[4:2];
        prot_nxt = HPROT_S;
        mst_nxt  = HMASTER_S;
      end
    end else if (DOWNSTREAM_READY_OUT && (st_r == bbw_pkg::ST_RMW_RD)) begin
      st_nxt     = bbw_pkg::ST_WB_ADDR;
      merged_nxt = lane_if.merged;
    end else if (DOWNSTREAM_READY_OUT && (st_r == bbw_pkg::ST_WB_ADDR)) begin
      st_nxt = bbw_pkg::ST_WB_DATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r       <= bbw_pkg::ST_PASS;
      rd_alias_r <= 1'b0;
      addr_r     <= bbw_pkg::WORD_RST;
      size_r     <= bbw_pkg::HSIZE_BYTE;
      bit_r      <= bbw_pkg::BIT_RST;
      prot_r     <= bbw_pkg::PROT_RST;
      mst_r      <= '0;
      merged_r   <= bbw_pkg::WORD_RST;
    end else begin
      st_r       <= st_nxt;
      rd_alias_r <= rd_alias_nxt;
      addr_r     <= addr_nxt;
      size_r     <= size_nxt;
      bit_r      <= bit_nxt;
      prot_r     <= prot_nxt;
      mst_r      <= mst_nxt;
      merged_r   <= merged_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  logic [4:0] pos_chk;
  assign pos_chk = {(ENDIAN_SELECT ? ~addr_r[1:0] : addr_r[1:0]), bit_r};

  sequence s_alias_rd;
    take_s && is_alias && !HWRITE_S;
  endsequence
  sequence s_alias_wr;
    take_s && is_alias && HWRITE_S;
  endsequence
  sequence s_rd_ok;
    (st_r == bbw_pkg::ST_RMW_RD) && DOWNSTREAM_READY_OUT && !DOWNSTREAM_RESPONSE;
  endsequence

  AST_REMAP_ADDR: assert property (pass_addr && HTRANS_S[1] && is_alias |->
    HADDR_M[31:20] == {HADDR_S[31:28], 8'h00} && HADDR_M[19:2] == HADDR_S[24:7])
    else $error("alias address not redirected to its bit-band region");
  AST_RD_SINGLE: assert property (s_alias_rd |-> !HWRITE_M && HTRANS_M[1] ##1
    st_r == bbw_pkg::ST_PASS && rd_alias_r)
    else $error("alias read produced more than one transfer");
  AST_RD_LSB: assert property (rd_alias_r && HREADYOUT_S |->
    HRDATA_S == {31'h0000_0000, HRDATA_M[pos_chk]})
    else $error("alias read data not the target bit in bit 0");
  AST_WR_READ_FIRST: assert property (s_alias_wr |-> !HWRITE_M && HMASTLOCK_M ##1
    st_r == bbw_pkg::ST_RMW_RD && !HREADYOUT_S)
    else $error("alias write did not start with a locked read");
  AST_LOCK_HELD: assert property ((st_r == bbw_pkg::ST_RMW_RD && !DOWNSTREAM_RESPONSE) ||
    st_r == bbw_pkg::ST_WB_ADDR |-> HMASTLOCK_M)
    else $error("lock dropped inside read-modify-write");
  AST_WB_MERGE: assert property (s_rd_ok |=> merged_r[pos_chk] == $past(HWDATA_S[0]) &&
    ((merged_r ^ $past(HRDATA_M)) & ~(32'h0000_0001 << pos_chk)) == 32'h0000_0000)
    else $error("write-back value wrong");
  AST_WB_ADDR: assert property (st_r == bbw_pkg::ST_WB_ADDR |-> HTRANS_M == bbw_pkg::HTRANS_NONSEQ &&
    HWRITE_M && HADDR_M == align_addr(addr_r, size_r) && HSIZE_M == size_r)
    else $error("write-back address phase wrong");
  AST_ERR_NO_WB: assert property (st_r == bbw_pkg::ST_RMW_RD && DOWNSTREAM_RESPONSE &&
    DOWNSTREAM_READY_OUT |-> HRESP_S ##1 st_r != bbw_pkg::ST_WB_ADDR)
    else $error("write-back issued after read error");
  AST_PASS_THRU: assert property (pass_addr && !is_alias |-> HADDR_M == HADDR_S &&
    HTRANS_M == HTRANS_S && HWRITE_M == HWRITE_S && HSIZE_M == HSIZE_S && HBURST_M == HBURST_S &&
    HPROT_M == HPROT_S && HMASTER_M == HMASTER_S && HMASTLOCK_M == HMASTLOCK_S)
    else $error("plain transfer altered");
  AST_SIZE_KEPT: assert property (s_alias_wr ##1 (st_r != bbw_pkg::ST_WB_ADDR) [*1] |->
    size_r == $past(HSIZE_S))
    else $error("transfer size not kept");

endmodule
`default_nettype wire

// ---- verilog/bbw_pkg.sv ----
// Overview of operation
// - Redirect alias-region data transfers to bit-band region
// - Two regions: lowest 1MB SRAM and peripheral
// - Alias offset equals byte times 32 plus bit times 4
// - Alias read makes exactly one downstream read
// - Selected bit returned in read data bit 0
// - Alias read data is 0x01 or 0x00
// - Alias write becomes locked read then write-back
// - Lock held over whole read-modify-write
// - Target bit takes write data bit 0
// - Write data bits 31 to 1 ignored
// - Downstream transfer keeps master's transfer size
// - Instruction fetches and other addresses pass unchanged
// - Direct bit-band region accesses pass normally
// - Master identifier width parameter, default 1
// - Endian select: 0 little, 1 big
package bbw_pkg;

  // --------------------------------------------------------------------------
  // Bus encodings
  // --------------------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic       HRESP_OKAY    = 1'h0;

  // --------------------------------------------------------------------------
  // Address map
  // --------------------------------------------------------------------------
  // Top seven address bits of the 32MB alias regions at 0x2200_0000 and 0x4200_0000
  localparam logic [6:0] ALIAS_SRAM_TAG = 7'h11;
  localparam logic [6:0] ALIAS_PERI_TAG = 7'h21;
  // Bits 27:20 of a 1MB bit-band region address
  localparam logic [7:0] BAND_GAP       = 8'h00;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [2:0]  BIT_RST  = 3'h0;
  localparam logic [3:0]  PROT_RST = 4'h0;

  typedef enum logic [1:0] {ST_PASS, ST_RMW_RD, ST_WB_ADDR, ST_WB_DATA} bbw_state_t;

endpackage

// ---- verilog/bbw_lane_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface bbw_lane_if;
  logic [31:0] rdata;
  logic [1:0]  byte_sel;
  logic [2:0]  bit_num;
  logic        wbit;
  logic        rbit;
  logic [31:0] merged;
  modport lane (input rdata, byte_sel, bit_num, wbit, output rbit, merged);
  modport user (output rdata, byte_sel, bit_num, wbit, input rbit, merged);
endinterface
`default_nettype wire

// ---- verilog/bbw_bit_lane.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbw_bit_lane #(
  parameter bit ENDIAN_SELECT = 1'b0
) (
  // Bit select and merge
  bbw_lane_if.lane lp
);

  logic [1:0] lane;
  logic [4:0] pos;

  always_comb begin
    // Big-endian lanes run the other way round within the word
    lane      = ENDIAN_SELECT ? ~lp.byte_sel : lp.byte_sel;
    pos       = {lane, lp.bit_num};
    lp.rbit   = lp.rdata[pos];
    lp.merged = lp.rdata;
    lp.merged[pos] = lp.wbit;
  end

endmodule
`default_nettype wire

// ---- verilog/bbw_dummy_none.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- testbench/bbw_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bbw_slave_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Downstream bus from the wrapper
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hlock,
  input  wire logic [31:0] hwdata,
  // Slave answer
  output logic [31:0]      hrdata,
  output logic             hready,
  output logic             hresp
);
  logic [31:0] mem [0:255];
  int          waits     = 0;
  logic        err_on    = 1'b0;
  logic [31:0] err_addr  = 32'h0000_0000;
  int          n_rd      = 0;
  int          n_wr      = 0;
  int          n_unlk    = 0;
  logic [31:0] last_addr = 32'h0000_0000;
  logic [2:0]  last_size = 3'h0;
  logic        act;
  logic        wr_r;
  logic        err1;
  logic [31:0] a_r;
  logic [2:0]  sz_r;
  logic [31:0] last_rd;
  logic [31:0] msk;
  logic        is_err;
  int          wcnt;

  // ----------------------------------------------------------------------
  // Answer, released data shows the inverse of the last word
  // ----------------------------------------------------------------------
  always_comb begin
    is_err = err_on && (a_r == err_addr);
    hready = !act || (wcnt == 0 && (!is_err || err1));
    hresp  = act && wcnt == 0 && is_err;
    hrdata = (act && !wr_r && hready) ? mem[a_r[9:2]] : ~last_rd;
    msk    = (sz_r == 3'h0) ? (32'h0000_00FF << {a_r[1:0], 3'h0}) :
             (sz_r == 3'h1) ? (32'h0000_FFFF << {a_r[1], 4'h0}) : 32'hFFFF_FFFF;
  end

  // ----------------------------------------------------------------------
  // Address and data phases
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act     <= 1'b0;
      err1    <= 1'b0;
      wcnt    <= 0;
      last_rd <= 32'h0000_0000;
    end else begin
      if (act && wcnt != 0) wcnt <= wcnt - 1;
      if (act && wcnt == 0 && is_err) err1 <= 1'b1;
      if (act && hready) begin
        act  <= 1'b0;
        err1 <= 1'b0;
        if (wr_r && !hresp) mem[a_r[9:2]] <= (mem[a_r[9:2]] & ~msk) | (hwdata & msk);
        if (!wr_r) last_rd <= hrdata;
      end
      if (hready && htrans[1]) begin
        act       <= 1'b1;
        a_r       <= haddr;
        wr_r      <= hwrite;
        sz_r      <= hsize;
        wcnt      <= waits;
        last_addr <= haddr;
        last_size <= hsize;
        if (hwrite) n_wr <= n_wr + 1;
        else n_rd <= n_rd + 1;
        if (!hlock) n_unlk <= n_unlk + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/ahb_bit_band_wrapper_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ahb_bit_band_wrapper_test;
  logic SYS_CLK, RST_B, HWRITE_S, HMASTLOCK_S, HREADYOUT_S, HRESP_S, HWRITE_M, HMASTLOCK_M, RDY, RSP;
  logic [31:0] HADDR_S, HWDATA_S, HRDATA_S, HADDR_M, HWDATA_M, HRDATA_M;
  logic [1:0] HTRANS_S, HTRANS_M;
  logic [2:0] HSIZE_S, HBURST_S, HSIZE_M, HBURST_M;
  logic [3:0] HPROT_S, HPROT_M;
  logic [0:0] HMASTER_S, HMASTER_M;
  logic HREADYOUT_B, HRESP_B, HWRITE_B, HMASTLOCK_B, RDY_B, RSP_B;
  logic [31:0] HRDATA_B, HADDR_B, HWDATA_B, HRDATA_MB, rd_big;
  logic [1:0] HTRANS_B;
  logic [2:0] HSIZE_B, HBURST_B;
  logic [3:0] HPROT_B;
  logic [0:0] HMASTER_B;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  bbw_wrapper dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .HADDR_S(HADDR_S), .HTRANS_S(HTRANS_S),
    .HWRITE_S(HWRITE_S), .HSIZE_S(HSIZE_S), .HBURST_S(HBURST_S), .HPROT_S(HPROT_S),
    .HMASTER_S(HMASTER_S), .HMASTLOCK_S(HMASTLOCK_S), .HWDATA_S(HWDATA_S), .HREADYOUT_S(HREADYOUT_S),
    .HRESP_S(HRESP_S), .HRDATA_S(HRDATA_S), .HADDR_M(HADDR_M), .HTRANS_M(HTRANS_M), .HWRITE_M(HWRITE_M),
    .HSIZE_M(HSIZE_M), .HBURST_M(HBURST_M), .HPROT_M(HPROT_M), .HMASTER_M(HMASTER_M),
    .HMASTLOCK_M(HMASTLOCK_M), .HWDATA_M(HWDATA_M), .HRDATA_M(HRDATA_M),
    .DOWNSTREAM_READY_OUT(RDY), .DOWNSTREAM_RESPONSE(RSP));
  bbw_slave_model m (.clk(SYS_CLK), .rst_b(RST_B), .haddr(HADDR_M), .htrans(HTRANS_M), .hwrite(HWRITE_M),
    .hsize(HSIZE_M), .hlock(HMASTLOCK_M), .hwdata(HWDATA_M), .hrdata(HRDATA_M), .hready(RDY), .hresp(RSP));
  // Big-endian copy on the same upstream stimulus, answered by a model of its own
  bbw_wrapper #(.ENDIAN_SELECT(1'b1)) dut_be (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .HADDR_S(HADDR_S),
    .HTRANS_S(HTRANS_S), .HWRITE_S(HWRITE_S), .HSIZE_S(HSIZE_S), .HBURST_S(HBURST_S), .HPROT_S(HPROT_S),
    .HMASTER_S(HMASTER_S), .HMASTLOCK_S(HMASTLOCK_S), .HWDATA_S(HWDATA_S), .HREADYOUT_S(HREADYOUT_B),
    .HRESP_S(HRESP_B), .HRDATA_S(HRDATA_B), .HADDR_M(HADDR_B), .HTRANS_M(HTRANS_B), .HWRITE_M(HWRITE_B),
    .HSIZE_M(HSIZE_B), .HBURST_M(HBURST_B), .HPROT_M(HPROT_B), .HMASTER_M(HMASTER_B),
    .HMASTLOCK_M(HMASTLOCK_B), .HWDATA_M(HWDATA_B), .HRDATA_M(HRDATA_MB),
    .DOWNSTREAM_READY_OUT(RDY_B), .DOWNSTREAM_RESPONSE(RSP_B));
  bbw_slave_model m_be (.clk(SYS_CLK), .rst_b(RST_B), .haddr(HADDR_B), .htrans(HTRANS_B), .hwrite(HWRITE_B),
    .hsize(HSIZE_B), .hlock(HMASTLOCK_B), .hwdata(HWDATA_B), .hrdata(HRDATA_MB), .hready(RDY_B), .hresp(RSP_B));

  // ----------------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      final_report();
    end
  end
  task final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  // Each phase holds until ready is seen high at a rising edge, and the answer is taken there;
  // the half-cycle wait at the end lets a write land in the model before anyone looks
  task automatic ahb(input logic [31:0] a, input logic w, input logic [2:0] s, input logic p0,
                     input logic [31:0] wd, output logic [31:0] rd, output logic rs);
    @(posedge SYS_CLK);
    HADDR_S <= a;
    HTRANS_S <= 2'h2;
    HWRITE_S <= w;
    HSIZE_S <= s;
    HPROT_S <= {3'h0, p0};
    do @(posedge SYS_CLK); while (HREADYOUT_S !== 1'b1);
    HTRANS_S <= 2'h0;
    HWDATA_S <= wd;
    do @(posedge SYS_CLK); while (HREADYOUT_S !== 1'b1);
    rd = HRDATA_S;
    rs = HRESP_S;
    rd_big = HRDATA_B;
    @(negedge SYS_CLK);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_read;
    logic [31:0] r;
    logic e;
    int n;
    m.mem[1] = 32'h0000_0800;
    m.mem[0] = 32'hFFFD_FFFF;
    n = m.n_rd;
    ahb(32'h2200_00AC, 1'b0, 3'h0, 1'b1, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0001, "alias read set bit");
    chk(m.n_rd - n, 1, "single downstream read");
    chk(m.last_addr, 32'h2000_0005, "remapped byte");
    ahb(32'h4200_0044, 1'b0, 3'h1, 1'b1, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000, "alias read clear bit");
    chk(m.last_addr, 32'h4000_0002, "peripheral remap");
    chk(m.last_size, 32'h0000_0001, "halfword kept");
  endtask
  task t_write;
    logic [31:0] r;
    logic e;
    int nr, nw, nu;
    m.mem[1] = 32'hFFFF_FFFF;
    nr = m.n_rd;
    nw = m.n_wr;
    nu = m.n_unlk;
    ahb(32'h2200_00AC, 1'b1, 3'h0, 1'b1, 32'hFFFF_FFFE, r, e);
    chk(m.mem[1], 32'hFFFF_F7FF, "bit cleared, others kept");
    chk(m.n_rd - nr, 1, "rmw read");
    chk(m.n_wr - nw, 1, "rmw write");
    chk(m.n_unlk - nu, 0, "lock held");
    m.waits = 2;
    ahb(32'h2200_00AC, 1'b1, 3'h2, 1'b1, 32'h0000_0001, r, e);
    chk(m.mem[1], 32'hFFFF_FFFF, "bit set with slow slave");
    chk(m.last_size, 32'h0000_0002, "word kept");
    m.waits = 0;
    ahb(32'h2200_00AC, 1'b1, 3'h0, 1'b1, 32'h0000_000E, r, e);
    chk(m.mem[1], 32'hFFFF_F7FF, "upper data ignored");
    chk(m.last_addr, 32'h2000_0005, "write-back address");
  endtask
  task t_pass;
    logic [31:0] r;
    logic e;
    m.mem[1] = 32'hA5A5_0001;
    ahb(32'h2200_0004, 1'b0, 3'h2, 1'b0, 32'h0000_0000, r, e);
    chk(r, 32'hA5A5_0001, "fetch data raw");
    chk(m.last_addr, 32'h2200_0004, "fetch address raw");
    ahb(32'h2000_0008, 1'b1, 3'h2, 1'b1, 32'h1234_5678, r, e);
    chk(m.mem[2], 32'h1234_5678, "direct write");
    ahb(32'h2000_0008, 1'b0, 3'h2, 1'b1, 32'h0000_0000, r, e);
    chk(r, 32'h1234_5678, "direct read");
  endtask
  // Both copies run in step here: same waits, no errors; only the lane differs
  task t_endian;
    logic [31:0] r;
    logic e;
    m_be.mem[1] = 32'h0008_0000;
    ahb(32'h2200_00AC, 1'b0, 3'h0, 1'b1, 32'h0000_0000, r, e);
    chk(rd_big, 32'h0000_0001, "big-endian lane read");
    ahb(32'h2200_00AC, 1'b1, 3'h2, 1'b1, 32'h0000_0000, r, e);
    chk(m_be.mem[1], 32'h0000_0000, "big-endian lane cleared");
  endtask
  task t_err;
    logic [31:0] r;
    logic e;
    int nw;
    m.err_on = 1'b1;
    m.err_addr = 32'h2000_0005;
    nw = m.n_wr;
    ahb(32'h2200_00AC, 1'b1, 3'h0, 1'b1, 32'h0000_0001, r, e);
    chk(e, 1, "read error forwarded");
    chk(m.n_wr - nw, 0, "write-back dropped");
    m.err_on = 1'b0;
  endtask

  initial begin
    RST_B = 1'b0;
    HADDR_S = 32'h0000_0000;
    HTRANS_S = 2'h0;
    HWRITE_S = 1'b0;
    HSIZE_S = 3'h0;
    HBURST_S = 3'h0;
    HPROT_S = 4'h1;
    HMASTER_S = 1'b0;
    HMASTLOCK_S = 1'b0;
    HWDATA_S = 32'h0000_0000;
    repeat (4) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    t_read();
    t_write();
    t_pass();
    t_endian();
    t_err();
    final_report();
  end
endmodule
`default_nettype wire
